// File: counter_pkg.sv
package counter_pkg;

    // Stage counts of the counter family
    localparam int unsigned STAGES      = 6;                // Binary, ripple and shift length
    localparam int unsigned PAIRS       = 3;                // Hybrid counter pairs
    localparam int unsigned DIV5_W      = 3;                // Divide-by-five shift stages
    localparam int unsigned DIVN_W      = 4;                // Divide-by-10/11 counter width

    // Reset values
    localparam logic [5:0]  STAGE_RST   = 6'h00;            // All stages clear
    localparam logic [5:0]  PAIR_RST    = 6'h00;            // Hybrid pairs clear
    localparam logic [2:0]  DIV5_RST    = 3'h0;             // Divide-by-five start
    localparam logic [3:0]  DIVN_RST    = 4'h0;             // Divider count start

    // Shift counter special states (bit 0 is the first stage)
    localparam logic [5:0]  ALL_ONES    = 6'h3F;            // Excluded lockup state
    localparam logic [5:0]  MLS_RECOVER = 6'h01;            // First stage set, rest clear
    localparam logic [5:0]  FIVE_ONES   = 6'h1F;            // First five stages set

    // Hybrid pair state that lets the next pair advance
    localparam logic [1:0]  PAIR_CARRY  = 2'h2;             // First=0, second=1

    // Divide-by-10/11 counts
    localparam logic [3:0]  DIV10_LAST  = 4'h9;             // Last count, divide by 10
    localparam logic [3:0]  DIV11_LAST  = 4'hA;             // Last count, divide by 11
    localparam logic [3:0]  DIVN_HIGH   = 4'h6;             // Counts with output high

    // Two-flop synchroniser stage for the external control pins
    typedef struct packed {
        logic [5:0] hold;                                   // Per-stage hold request
        logic [5:0] set;                                    // Per-stage direct set
        logic [5:0] clear;                                  // Per-stage direct clear
        logic       div11;                                  // Divide-by-11 select
    } ctrl_t;

    // Whole state of the counter set
    typedef struct packed {
        ctrl_t       sync1;                                 // First synchroniser rank
        ctrl_t       sync2;                                 // Second synchroniser rank
        logic [5:0]  bin;                                   // Synchronous binary counter
        logic [5:0]  ripple;                                // Ripple counter stages
        logic        ripple_tc;                             // Divide-by-64 terminal count
        logic [5:0]  mls;                                   // Maximal-length shift counter
        logic [5:0]  full;                                  // Full-length shift counter
        logic [5:0]  hybrid;                                // Paired count-by-4 counter
        logic        toggle;                                // Prescaler input toggle stage
        logic [2:0]  div5;                                  // Prescaler divide-by-five
        logic        pre_out;                               // Prescaler output
        logic [3:0]  divn;                                  // Divide-by-10/11 count
        logic        divn_last11;                           // Modulus latched at wrap
        logic        divn_out;                              // Divide-by-10/11 output
    } state_t;

endpackage : counter_pkg

// File: counter_set.sv
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// [R1] Binary stages toggle, loading their own inverse
// [R2] Binary first stage toggles every clock
// [R3] Higher stage toggles when all lower ones
// [R4] Ripple terminal count marks all-ones state
// [R5] Shift counter: toggle first when last zero
// [R6] All-ones lockup forces first-stage-only state
// [R7] That feedback only for listed stage counts
// [R8] Full variant includes all-ones, 64 states
// [R9] Hybrid pair advances when lower pairs 01
// [R10] Toggle stage clocks divide-by-five shift counter
// [R11] Prescaler 60/40 duty, no lockup states
// [R12] Basic divider gives one cycle per ten
// [R13] External select chooses divide 10 or 11
// [R14] Stages change on edges; set/clear override
// [R15] Outside logic changes enables while clock high
// [R16] Reset clears every counter stage
// [R17] Held enable freezes that stage's value
module counter_set
    import counter_pkg::*;
(
    input  wire logic       clk,            // Count clock, 100 MHz
    input  wire logic       rst_b,          // Synchronous reset, active low
    input  wire logic [5:0] stage_hold,     // Per-stage hold, high freezes stage
    input  wire logic [5:0] stage_set,      // Per-stage direct set, active high
    input  wire logic [5:0] stage_clear,    // Per-stage direct clear, active high
    input  wire logic       div11_sel,      // High selects divide by 11
    output logic      [5:0] bin_count,      // Synchronous binary count
    output logic      [5:0] ripple_count,   // Ripple counter stages
    output logic            ripple_tc,      // Divide-by-64 terminal count
    output logic      [5:0] mls_count,      // Maximal-length shift counter
    output logic      [5:0] full_count,     // Full-length shift counter
    output logic      [5:0] hybrid_count,   // Paired count-by-4 counter
    output logic            first_stage_output, // Shift counter first stage
    output logic            last_stage_output,  // Shift counter last stage
    output logic            pre_out,        // Divide-by-ten prescaler output
    output logic            divn_out        // Divide-by-10/11 output
);

    // Stage counts for which toggle-on-last-zero feedback is maximal
    function automatic logic len_ok(input int unsigned n);
        len_ok = (n == 2) || (n == 3) || (n == 4) || (n == 6) ||
                 (n == 7) || (n == 15) || (n == 22);                    // [R7]
    endfunction : len_ok

    localparam logic MLS_FEEDBACK_OK = len_ok(STAGES);  // Feedback choice per length

    state_t s_q;                            // Registered state
    state_t s_d;                            // Next state

    // Next-state logic for every counter in the set
    always_comb begin
        logic       carry;                  // All lower binary stages are one
        logic       pair_go;                // All lower pairs in carry state
        logic       fb;                     // Shift counter feedback
        logic [3:0] last;                   // Active divider last count
        s_d = s_q;
        carry = 1'b1;
        pair_go = 1'b1;
        fb = 1'b0;
        last = DIV10_LAST;

        // Pin inputs cross into the clock domain by two flops
        s_d.sync1 = '{hold: stage_hold, set: stage_set, clear: stage_clear, div11: div11_sel};
        s_d.sync2 = s_q.sync1;

        // Synchronous binary counter; hold acts as the second ORed clock input
        for (int i = 0; i < STAGES; i++) begin
            // Hold request is expected to move only while the clock is high
            if (carry && !s_q.sync2.hold[i]) begin                      // [R15] [R17]
                s_d.bin[i] = ~s_q.bin[i];                               // [R1] [R2] [R3]
            end
            // Direct set and clear win over counting
            if (s_q.sync2.set[i]) begin                                 // [R14]
                s_d.bin[i] = 1'b1;
            end else if (s_q.sync2.clear[i]) begin                      // [R14]
                s_d.bin[i] = 1'b0;
            end
            carry = carry & s_q.bin[i];
        end

        // Ripple counter: settling is free at one clock, so modelled as binary
        s_d.ripple = s_q.ripple + 6'h01;                                // [R1]
        // Terminal count moves only entering and leaving all ones
        s_d.ripple_tc = (s_d.ripple == ALL_ONES);                       // [R4]

        // Maximal-length shift counter, first stage is bit 0
        if (MLS_FEEDBACK_OK) begin
            fb = s_q.mls[0] ^ ~s_q.mls[STAGES-1];                       // [R5] [R7]
        end else begin
            // Other lengths fall back to a twisted-ring feedback
            fb = ~s_q.mls[STAGES-1];                                    // [R7]
        end
        s_d.mls = {s_q.mls[STAGES-2:0], fb};                            // [R5]
        if (s_q.mls == ALL_ONES) begin
            // Recover from the lockup state, making all-zeros terminal
            s_d.mls = MLS_RECOVER;                                      // [R6]
        end

        // Full-length variant: invert feedback when the first five are one
        s_d.full = {s_q.full[STAGES-2:0],
                    s_q.full[0] ^ ~s_q.full[STAGES-1] ^
                    (s_q.full[STAGES-2:0] == FIVE_ONES[STAGES-2:0])};   // [R8]

        // Hybrid counter: Johnson pairs chained on the carry state
        for (int p = 0; p < PAIRS; p++) begin
            if (pair_go) begin
                s_d.hybrid[2*p]   = ~s_q.hybrid[2*p+1];                 // [R9]
                s_d.hybrid[2*p+1] = s_q.hybrid[2*p];                    // [R9]
            end
            pair_go = pair_go & (s_q.hybrid[2*p +: 2] == PAIR_CARRY);   // [R9]
        end

        // Prescaler: divide by two, then rising toggle steps the by-five
        s_d.toggle = ~s_q.toggle;                                       // [R10]
        if (!s_q.toggle) begin
            // Loop 000,001,011,110,100; unused codes fall back within two steps
            s_d.div5 = {s_q.div5[1:0], ~(s_q.div5[1] | s_q.div5[2])};   // [R10] [R11]
        end
        // Last stage low for three of five steps gives 60/40
        s_d.pre_out = ~s_d.div5[2];                                     // [R11] [R12]

        // Divide-by-10/11; modulus changes only at wrap to avoid short cycles
        last = s_q.divn_last11 ? DIV11_LAST : DIV10_LAST;               // [R13]
        if (s_q.divn == last) begin
            s_d.divn = DIVN_RST;
            s_d.divn_last11 = s_q.sync2.div11;                          // [R13]
        end else begin
            s_d.divn = s_q.divn + 4'h1;                                 // [R12]
        end
        s_d.divn_out = (s_d.divn < DIVN_HIGH);                          // [R12]
    end

    // State register with synchronous reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_q <= '0;
            s_q.bin <= STAGE_RST;                                       // [R16]
            s_q.ripple <= STAGE_RST;                                    // [R16]
            s_q.mls <= STAGE_RST;                                       // [R16]
            s_q.full <= STAGE_RST;                                      // [R16]
            s_q.hybrid <= PAIR_RST;                                     // [R16]
            s_q.div5 <= DIV5_RST;                                       // [R16]
            s_q.divn <= DIVN_RST;                                       // [R16]
            s_q.pre_out <= 1'b1;
            s_q.divn_out <= 1'b1;
        end else begin
            s_q <= s_d;                                                 // [R14]
        end
    end

    // Outputs straight from flops
    assign bin_count          = s_q.bin;
    assign ripple_count       = s_q.ripple;
    assign ripple_tc          = s_q.ripple_tc;
    assign mls_count          = s_q.mls;
    assign full_count         = s_q.full;
    assign hybrid_count       = s_q.hybrid;
    assign first_stage_output = s_q.mls[0];
    assign last_stage_output  = s_q.mls[STAGES-1];
    assign pre_out            = s_q.pre_out;
    assign divn_out           = s_q.divn_out;

endmodule : counter_set

`default_nettype wire

// File: counter_set_chk.sv
`timescale 1ns/1ns
`default_nettype none
// Port-level watcher for the counter set
module counter_set_chk
    import counter_pkg::*;
(
    input wire logic       clk,                // Count clock
    input wire logic       rst_b,              // Sync reset
    input wire logic [5:0] stage_hold,         // Hold pins
    input wire logic [5:0] stage_set,          // Set pins
    input wire logic [5:0] stage_clear,        // Clear pins
    input wire logic       div11_sel,          // Modulus pin
    input wire logic [5:0] bin_count,          // Binary
    input wire logic [5:0] ripple_count,       // Ripple
    input wire logic       ripple_tc,          // Terminal count
    input wire logic [5:0] mls_count,          // Short shift
    input wire logic [5:0] full_count,         // Full shift
    input wire logic [5:0] hybrid_count,       // Pairs
    input wire logic       first_stage_output, // Shift first
    input wire logic       last_stage_output,  // Shift last
    input wire logic       pre_out,            // Prescaler
    input wire logic       divn_out            // Divide by N
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [17:0] pins;  // Pins lumped for the sync delay
    logic [2:0]  rst_q; // Reset history, synchronisers flushed
    logic [5:0]  mls_q; // Previous shift states
    logic [5:0]  full_q;
    logic [5:0]  hyb_q;
    logic        run;
    assign pins = {stage_hold, stage_set, stage_clear};
    assign run = &rst_q;
    // Previous values, kept free of reset on purpose
    always_ff @(posedge clk) begin
        rst_q  <= {rst_q[1:0], rst_b};
        mls_q  <= mls_count;
        full_q <= full_count;
        hyb_q  <= hybrid_count;
    end
    reset_clear_a: assert property (disable iff (1'b0) !rst_b |=> bin_count == STAGE_RST
        && mls_count == STAGE_RST && hybrid_count == PAIR_RST && pre_out && divn_out)
        else $error("counters not cleared by reset");
    bin_count_a: assert property (run && $past(pins, 3) == 18'h0
        |-> bin_count == $past(bin_count) + 6'h01) else $error("binary step wrong");
    bin_hold_a: assert property (run && $past(pins, 3) == {6'h3F, 12'h0}
        |-> $stable(bin_count)) else $error("held stage moved");
    bin_set_a: assert property (run && $past(stage_set, 3) == 6'h3F
        |-> bin_count == 6'h3F) else $error("direct set ignored");
    ripple_a: assert property ($past(rst_b) |-> ripple_count == $past(ripple_count) + 6'h01
        && ripple_tc == (ripple_count == 6'h3F)) else $error("ripple or terminal count wrong");
    mls_a: assert property ($past(rst_b) |-> mls_count == (mls_q == ALL_ONES ? MLS_RECOVER
        : {mls_q[4:0], mls_q[0] ^ ~mls_q[5]}) && first_stage_output == mls_count[0]
        && last_stage_output == mls_count[5]) else $error("short shift step wrong");
    full_a: assert property ($past(rst_b) |-> full_count == {full_q[4:0],
        full_q[0] ^ ~full_q[5] ^ (full_q[4:0] == 5'h1F)}) else $error("full shift step wrong");
    hybrid_a: assert property ($past(rst_b) |-> hybrid_count[1:0] == {hyb_q[0], ~hyb_q[1]}
        && hybrid_count[3:2] == (hyb_q[1:0] == PAIR_CARRY ? {hyb_q[2], ~hyb_q[3]} : hyb_q[3:2]))
        else $error("hybrid pair step wrong");
    pre_duty_a: assert property ($rose(pre_out) |-> pre_out[*6] ##1 !pre_out[*4] ##1 pre_out)
        else $error("prescaler shape wrong");
    divn_shape_a: assert property ($rose(divn_out) |-> divn_out[*6] ##1 !divn_out[*4]
        ##1 (divn_out or (!divn_out ##1 divn_out))) else $error("divider shape wrong");
    // Main scenarios reached
    cover property (run && $past(stage_set, 3) == 6'h3F);
    cover property (full_count == ALL_ONES);
    cover property ($fell(divn_out) ##1 !divn_out[*4]);
endmodule : counter_set_chk
`default_nettype wire

// File: ctrl_src.sv
`timescale 1ns/1ns
`default_nettype none
// Outside control logic driving the pin levels
module ctrl_src
    import counter_pkg::*;
(
    input  wire logic clk,  // Count clock
    input  wire ctrl_t req, // Wanted levels
    output var  ctrl_t pins // Levels at the counter
);
    initial pins = '0;
    // Levels move just after a rising edge, so only while the clock is high
    always @(posedge clk) begin
        pins <= req;
    end
endmodule : ctrl_src
`default_nettype wire

// File: counter_set_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module counter_set_tb_top;
    import counter_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    ctrl_t req = '0;
    ctrl_t pins;
    logic [5:0] bin, rip, mls, full, hyb;
    logic tc, f0, l5, pre, dn;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    initial forever #5 clk = ~clk;
    ctrl_src ctrl_src_inst (.clk(clk), .req(req), .pins(pins));
    counter_set counter_set_inst (.clk(clk), .rst_b(rst_b), .stage_hold(pins.hold),
        .stage_set(pins.set), .stage_clear(pins.clear), .div11_sel(pins.div11),
        .bin_count(bin), .ripple_count(rip), .ripple_tc(tc), .mls_count(mls),
        .full_count(full), .hybrid_count(hyb), .first_stage_output(f0),
        .last_stage_output(l5), .pre_out(pre), .divn_out(dn));
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wrap_up;
        if (err_count == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up
    // Hang guard, well above the whole run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            wrap_up;
        end
    end
    function logic pick(input int s);
        case (s)
            0: pick = (mls == 6'h00);
            1: pick = (full == 6'h00);
            2: pick = tc;
            3: pick = pre;
            4: pick = dn;
            default: pick = (hyb == 6'h00);
        endcase
    endfunction : pick
    // Cycles between two rises of one output, and cycles spent high
    task period(input int s, output int per, output int hi);
        logic v, p;
        v = 1'b1;
        do begin @(posedge clk); #1 p = v; v = pick(s); end while (!(v && !p));
        per = 0;
        hi = 0;
        do begin @(posedge clk); #1 p = v; v = pick(s); per++; hi += v; end while (!(v && !p));
    endtask : period
    task t_reset;
        repeat (5) @(posedge clk);
        #1 chk({bin, pre, dn}, 8'h03);
        chk({mls, tc, f0}, 8'h00);
        @(posedge clk) rst_b <= 1'b1;
    endtask : t_reset
    task t_count;
        for (int i = 1; i <= 70; i++) begin
            @(posedge clk);
            #1 chk({2'b00, bin}, 8'(i % 64));
            chk({1'b0, tc, rip}, {1'b0, i % 64 == 63, 6'(i % 64)});
        end
    endtask : t_count
    // Set beats clear, clear works under hold, hold freezes
    task t_pins;
        @(posedge clk) req <= '{6'h3F, 6'h3F, 6'h3F, 1'b0};
        repeat (6) @(posedge clk);
        #1 chk({2'b00, bin}, 8'h3F);
        @(posedge clk) req <= '{6'h3F, 6'h00, 6'h15, 1'b0};
        repeat (6) @(posedge clk);
        #1 chk({2'b00, bin}, 8'h2A);
        @(posedge clk) req.clear <= 6'h00;
        repeat (8) @(posedge clk);
        #1 chk({2'b00, bin}, 8'h2A);
        @(posedge clk) req.hold <= 6'h00;
    endtask : t_pins
    task t_periods;
        int per, hi;
        int ep[6] = '{63, 64, 64, 10, 10, 64};
        int eh[6] = '{1, 1, 1, 6, 6, 1};
        for (int s = 0; s < 6; s++) begin
            period(s, per, hi);
            chk(8'(per), 8'(ep[s]));
            chk(8'(hi), 8'(eh[s]));
        end
        @(posedge clk) req.div11 <= 1'b1;
        repeat (30) @(posedge clk);
        period(4, per, hi);
        chk(8'(per), 8'h0B);
        chk(8'(hi), 8'h06);
    endtask : t_periods
    initial begin
        t_reset;
        t_count;
        t_pins;
        t_periods;
        wrap_up;
    end
endmodule : counter_set_tb_top
bind counter_set counter_set_chk counter_set_chk_inst (.clk(clk), .rst_b(rst_b),
    .stage_hold(stage_hold), .stage_set(stage_set), .stage_clear(stage_clear),
    .div11_sel(div11_sel), .bin_count(bin_count), .ripple_count(ripple_count),
    .ripple_tc(ripple_tc), .mls_count(mls_count), .full_count(full_count),
    .hybrid_count(hybrid_count), .first_stage_output(first_stage_output),
    .last_stage_output(last_stage_output), .pre_out(pre_out), .divn_out(divn_out));
`default_nettype wire
